/* File: src/vmo_pkg.sv */
// Behaviour
// - mask logic uses one register, grouping untouched
// - bits below start kept, start cleared after
// - mask logic unmasked; masked encoding is reserved
// - mask logic tail bits filled agnostically
// - destination may equal either source
// - and, nand, and-inverted, exclusive-or per bit
// - or, nor, or-inverted, equivalence per bit
// - clear, set, copy, invert map onto base ops
// - count active set bits, honour implicit mask
// - count written as zero when length zero
// - nonzero start traps count, find, scans
// - find writes lowest active set index or -1
// - find writes -1 when length zero
// - before-first sets bits ahead of first one
// - no set source bit gives all ones
// - including-first also sets the first one
// - only-first sets just the first one
// - scan tail bits filled agnostically
package vmo_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int VLEN = 32;
  localparam int VL_W = 6;
  localparam int VS_W = 5;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VLEN = 8'h04;
  localparam logic [7:0] OFS_VSTART = 8'h08;
  localparam logic [7:0] OFS_SRC2 = 8'h0C;
  localparam logic [7:0] OFS_SRC1 = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_DEST = 8'h18;
  localparam logic [7:0] OFS_SCALAR = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_GO = 8'h24;

  // ---------------------------------------------------------------
  // operation codes (control bits 4:0)
  // ---------------------------------------------------------------
  localparam logic [4:0] OP_AND = 5'h00;
  localparam logic [4:0] OP_NAND = 5'h01;
  localparam logic [4:0] OP_ANDN = 5'h02;
  localparam logic [4:0] OP_XOR = 5'h03;
  localparam logic [4:0] OP_OR = 5'h04;
  localparam logic [4:0] OP_NOR = 5'h05;
  localparam logic [4:0] OP_ORN = 5'h06;
  localparam logic [4:0] OP_XNOR = 5'h07;
  localparam logic [4:0] OP_CLR = 5'h08;
  localparam logic [4:0] OP_SET = 5'h09;
  localparam logic [4:0] OP_MV = 5'h0A;
  localparam logic [4:0] OP_NOT = 5'h0B;
  localparam logic [4:0] OP_POP = 5'h0C;
  localparam logic [4:0] OP_FIRST = 5'h0D;
  localparam logic [4:0] OP_SBF = 5'h0E;
  localparam logic [4:0] OP_SIF = 5'h0F;
  localparam logic [4:0] OP_SOF = 5'h10;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ST_DONE = 0;
  localparam int ST_TRAP = 1;
  localparam int ST_SCALAR = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] NONE_FOUND = 32'hFFFF_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // control word: mask agnostic, unmasked select, operation
  typedef struct packed {
    logic [24:0] unused;
    logic mask_agnostic;
    logic mask_select_bit;
    logic [4:0] op;
  } vmo_ctrl_t;

  // outcome of one execution
  typedef struct packed {
    logic trap;
    logic dest_we;
    logic scalar_we;
    logic [VLEN-1:0] dest;
    logic [31:0] scalar;
  } vmo_result_t;

endpackage

/* File: src/vmo_top.sv */
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module vmo_top
  import vmo_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // write address channel
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // write data channel
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // write response channel
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // read address channel
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // read data channel
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // true for a mapped register offset
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_VLEN) || (a == OFS_VSTART) ||
             (a == OFS_SRC2) || (a == OFS_SRC1) || (a == OFS_MASK) ||
             (a == OFS_DEST) || (a == OFS_SCALAR) || (a == OFS_STATUS) ||
             (a == OFS_GO);
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int k = 0; k < 4; k++)
    begin
      if (strb[k])
        merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // count of set bits
  function automatic logic [31:0] pop_count(input logic [VLEN-1:0] v);
    logic [VL_W-1:0] acc;
    acc = '0;
    for (int k = 0; k < VLEN; k++)
      acc = acc + VL_W'(v[k]);
    pop_count = {{(32-VL_W){1'b0}}, acc};
  endfunction

  // index of lowest set bit, all ones when none
  function automatic logic [31:0] first_set(input logic [VLEN-1:0] v);
    first_set = NONE_FOUND;
    for (int k = VLEN - 1; k >= 0; k--)
    begin
      if (v[k])
        first_set = 32'(k);
    end
  endfunction

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_r, rst_n;

  // two-stage release, assert at once
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  vmo_ctrl_t ctrl_r;
  logic [VL_W-1:0] vl_r;
  logic [VS_W-1:0] vstart_r;
  logic [VLEN-1:0] src2_r, src1_r, mask_r, dest_r;
  logic [31:0] scalar_r;
  logic [2:0] status_r;
  logic go_r;

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  logic aw_full_r, w_full_r, bvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire wr_commit = aw_full_r && w_full_r && !bvalid_r;
  wire wr_hit = wr_commit && mapped(aw_addr_r);

  // per-register write strobes
  wire we_ctrl = wr_hit && (aw_addr_r == OFS_CTRL);
  wire we_vlen = wr_hit && (aw_addr_r == OFS_VLEN);
  wire we_vstart = wr_hit && (aw_addr_r == OFS_VSTART);
  wire we_src2 = wr_hit && (aw_addr_r == OFS_SRC2);
  wire we_src1 = wr_hit && (aw_addr_r == OFS_SRC1);
  wire we_mask = wr_hit && (aw_addr_r == OFS_MASK);
  wire we_dest = wr_hit && (aw_addr_r == OFS_DEST);
  wire we_status = wr_hit && (aw_addr_r == OFS_STATUS);
  wire we_go = wr_hit && (aw_addr_r == OFS_GO);

  // ready while the holding slot is empty and no write response is pending
  assign S_AXI_AWREADY = !aw_full_r && !bvalid_r;
  assign S_AXI_WREADY = !w_full_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  // address and data slots, taken in either order
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= RST_WORD;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      else if (wr_commit)
        aw_full_r <= 1'b0;
      if (w_take)
      begin
        w_full_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      else if (wr_commit)
        w_full_r <= 1'b0;
    end
  end

  // response one cycle after the commit
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // operand selection
  // ---------------------------------------------------------------
  wire [4:0] op = ctrl_r.op;
  wire unmasked = ctrl_r.mask_select_bit;
  wire is_short = (op == OP_CLR) || (op == OP_SET) || (op == OP_MV) || (op == OP_NOT);
  wire is_logic = (op <= OP_XNOR) || is_short;
  wire is_scan = (op == OP_SBF) || (op == OP_SIF) || (op == OP_SOF);
  wire is_scalar = (op == OP_POP) || (op == OP_FIRST);
  wire legal = is_logic || is_scan || is_scalar;

  // shorthand forms fold onto a base op and operand pair
  wire [4:0] base_op = (op == OP_CLR) ? OP_XOR :
                       (op == OP_SET) ? OP_XNOR :
                       (op == OP_MV) ? OP_AND :
                       (op == OP_NOT) ? OP_NAND : op;
  wire [VLEN-1:0] opa = ((op == OP_CLR) || (op == OP_SET)) ? dest_r : src2_r;
  wire [VLEN-1:0] opb = ((op == OP_CLR) || (op == OP_SET)) ? dest_r :
                        ((op == OP_MV) || (op == OP_NOT)) ? src2_r : src1_r;

  // ---------------------------------------------------------------
  // bitwise mask logic on one register
  // ---------------------------------------------------------------
  logic [VLEN-1:0] logic_val;

  // single register operands regardless of grouping; a is source two, or the destination for clear and set
  always_comb
  begin
    case (base_op)
      OP_AND: logic_val = opa & opb;
      OP_NAND: logic_val = ~(opa & opb);
      OP_ANDN: logic_val = opa & ~opb;
      OP_XOR: logic_val = opa ^ opb;
      OP_OR: logic_val = opa | opb;
      OP_NOR: logic_val = ~(opa | opb);
      OP_ORN: logic_val = opa | ~opb;
      OP_XNOR: logic_val = ~(opa ^ opb);
      default: logic_val = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // per-element masks and scan
  // ---------------------------------------------------------------
  logic [VLEN-1:0] body, prestart, active, seen, logic_dest, scan_dest;
  wire [VLEN-1:0] hits = src2_r & active;
  // seen[i]: an active set source bit lies below i
  assign seen[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < VLEN; gi++)
    begin : g_elem
      wire scan_bit;
      assign body[gi] = VL_W'(gi) < vl_r;
      assign prestart[gi] = VS_W'(gi) < vstart_r;
      assign active[gi] = body[gi] && (unmasked || mask_r[gi]);
      if (gi > 0)
      begin : g_seen
        assign seen[gi] = seen[gi-1] || hits[gi-1];
      end
      // scan value for an active element
      assign scan_bit = (op == OP_SBF) ? !seen[gi] && !hits[gi] :
                        (op == OP_SIF) ? !seen[gi] :
                        !seen[gi] && hits[gi];
      // below start kept, tail agnostic ones, body computed
      assign logic_dest[gi] = prestart[gi] ? dest_r[gi] :
                              !body[gi] ? 1'b1 :
                              logic_val[gi];
      // tail agnostic ones, inactive per mask policy
      assign scan_dest[gi] = !body[gi] ? 1'b1 :
                             active[gi] ? scan_bit :
                             ctrl_r.mask_agnostic ? 1'b1 : dest_r[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // execution outcome
  // ---------------------------------------------------------------
  vmo_result_t res;
  wire start_nz = vstart_r != '0;

  // trap on reserved masked logic, nonzero start with count, find or scan, unknown op
  assign res.trap = !legal || (is_logic && !unmasked) ||
                    ((is_scan || is_scalar) && start_nz);
  assign res.dest_we = !res.trap && (is_logic || is_scan);
  assign res.scalar_we = !res.trap && is_scalar;
  assign res.dest = is_scan ? scan_dest : logic_dest;
  assign res.scalar = (op == OP_POP) ? pop_count(hits) :
                      first_set(hits);

  // ---------------------------------------------------------------
  // register updates
  // ---------------------------------------------------------------
  // software-written configuration and operands
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= '0;
      vl_r <= '0;
      src2_r <= '0;
      src1_r <= '0;
      mask_r <= '0;
    end
    else
    begin
      if (we_ctrl)
        ctrl_r <= vmo_ctrl_t'(merge(32'(ctrl_r), w_data_r, w_strb_r) & 32'h0000_007F);
      if (we_vlen)
        vl_r <= merge(32'(vl_r), w_data_r, w_strb_r) > 32'(VLEN) ? VL_W'(VLEN) :
                VL_W'(merge(32'(vl_r), w_data_r, w_strb_r));
      if (we_src2)
        src2_r <= merge(src2_r, w_data_r, w_strb_r);
      if (we_src1)
        src1_r <= merge(src1_r, w_data_r, w_strb_r);
      if (we_mask)
        mask_r <= merge(mask_r, w_data_r, w_strb_r);
    end
  end

  // start index cleared by every executed instruction
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      vstart_r <= '0;
    else if (go_r)
      vstart_r <= '0;
    else if (we_vstart)
      vstart_r <= VS_W'(merge(32'(vstart_r), w_data_r, w_strb_r));
  end

  // execution pulse one cycle after the go write
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      go_r <= 1'b0;
    else
      go_r <= we_go;
  end

  // destination and scalar result, results read before written
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dest_r <= '0;
      scalar_r <= RST_WORD;
    end
    else
    begin
      if (go_r && res.dest_we)
        dest_r <= res.dest;
      else if (we_dest)
        dest_r <= merge(dest_r, w_data_r, w_strb_r);
      if (go_r && res.scalar_we)
        scalar_r <= res.scalar;
    end
  end

  // sticky status, write one to clear, a new event wins
  wire [2:0] st_set = {go_r && res.scalar_we, go_r && res.trap, go_r};
  wire [2:0] st_clr = we_status ? w_data_r[2:0] & {3{w_strb_r[0]}} : 3'b000;
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= 3'b000;
    else
      status_r <= (status_r & ~st_clr) | st_set;
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

  // read word selection
  wire [7:0] ra = S_AXI_ARADDR;
  wire [31:0] rd_word = (ra == OFS_CTRL) ? 32'(ctrl_r) :
                        (ra == OFS_VLEN) ? 32'(vl_r) :
                        (ra == OFS_VSTART) ? 32'(vstart_r) :
                        (ra == OFS_SRC2) ? src2_r :
                        (ra == OFS_SRC1) ? src1_r :
                        (ra == OFS_MASK) ? mask_r :
                        (ra == OFS_DEST) ? dest_r :
                        (ra == OFS_SCALAR) ? scalar_r :
                        (ra == OFS_STATUS) ? 32'(status_r) : RST_WORD;

  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // registered read answer, one cycle after the address
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= RST_WORD;
      rresp_r <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

endmodule

/* File: test/vector_mask_ops_test.sv */
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module vector_mask_ops_test
  import vmo_pkg::*;
();
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  int err_total = 0;
  int checks_done = 0;
  integer seed = 32'h0512_e91b;
  // model state
  logic [31:0] m_dest, m_scalar, m_src2, m_src1, m_mask, e_st, st_m, rdv;
  int m_vl, m_vs;
  logic [4:0] m_op;
  logic m_sel, m_ma;
  logic [1:0] resp;
  bit ok;

  always #2 clk_sys = ~clk_sys;

  // bus master and device
  vmo_axi_bfm bfm (.clk(clk_sys));
  vmo_top dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .S_AXI_AWVALID(bfm.awvalid), .S_AXI_AWREADY(bfm.awready), .S_AXI_AWADDR(bfm.awaddr),
    .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(bfm.wvalid), .S_AXI_WREADY(bfm.wready),
    .S_AXI_WDATA(bfm.wdata), .S_AXI_WSTRB(bfm.wstrb), .S_AXI_BVALID(bfm.bvalid),
    .S_AXI_BREADY(bfm.bready), .S_AXI_BRESP(bfm.bresp), .S_AXI_ARVALID(bfm.arvalid),
    .S_AXI_ARREADY(bfm.arready), .S_AXI_ARADDR(bfm.araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(bfm.rvalid), .S_AXI_RREADY(bfm.rready), .S_AXI_RDATA(bfm.rdata),
    .S_AXI_RRESP(bfm.rresp));

  // verdict and end of run
  task automatic test_done();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // checked write and masked read
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bfm.wr(a, d, resp, ok);
    if (!ok)
    begin
      err_total++;
      test_done();
    end
    else
      `CHK(resp, er)
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    bfm.rd(a, rdv, resp, ok);
    if (!ok)
    begin
      err_total++;
      test_done();
    end
    else
    begin
      `CHK(resp, er)
      `CHK(rdv & m, e)
    end
  endtask

  // reference execution of one go
  function automatic void run_model();
    logic [31:0] lw, res;
    logic trap, act, f;
    int i, cnt, fst;
    trap = (m_op <= OP_NOT) ? !m_sel : (m_op > OP_SOF) || (m_vs != 0);
    cnt = 0;
    fst = -1;
    res = m_dest;
    case (m_op)
      OP_AND: lw = m_src2 & m_src1;
      OP_NAND: lw = ~(m_src2 & m_src1);
      OP_ANDN: lw = m_src2 & ~m_src1;
      OP_XOR: lw = m_src2 ^ m_src1;
      OP_OR: lw = m_src2 | m_src1;
      OP_NOR: lw = ~(m_src2 | m_src1);
      OP_ORN: lw = m_src2 | ~m_src1;
      OP_XNOR: lw = ~(m_src2 ^ m_src1);
      OP_SET: lw = ALL;
      OP_MV: lw = m_src2;
      OP_NOT: lw = ~m_src2;
      default: lw = 32'h0000_0000;
    endcase
    for (i = 0; i < 32; i++)
    begin
      act = i < m_vl && (m_sel || m_mask[i]);
      f = act && m_src2[i] && fst < 0;
      if (act && m_src2[i])
        cnt++;
      if (f)
        fst = i;
      if (m_op <= OP_NOT)
        res[i] = (i < m_vs) ? m_dest[i] : (i >= m_vl || lw[i]);
      else if (i >= m_vl || (!act && m_ma))
        res[i] = 1'b1;
      else if (act)
        res[i] = (m_op == OP_SOF) ? f : (m_op == OP_SIF) ? (fst < 0 || f) : (fst < 0);
    end
    e_st = trap ? 32'h0000_0002 : (m_op == OP_POP || m_op == OP_FIRST) ? 32'h5 : 32'h1;
    st_m = trap ? 32'h0000_0006 : 32'h0000_0007;
    if (!trap && m_op != OP_POP && m_op != OP_FIRST)
      m_dest = res;
    if (!trap && m_op == OP_POP)
      m_scalar = 32'(cnt);
    if (!trap && m_op == OP_FIRST)
      m_scalar = 32'(fst);
    m_vs = 0;
  endfunction

  // main sequence
  initial
  begin
    m_scalar = 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int a = 0; a <= 'h24; a += 4)
      rdc(8'(a), ALL, RST_WORD, RESP_OKAY);
    rdc(8'h28, ALL, RST_WORD, RESP_SLVERR);
    wrc(8'h2c, 32'h1234_5678, RESP_SLVERR);
    for (int k = 0; k < 136; k++)
    begin
      m_op = 5'(k % 18);
      m_sel = ($random(seed) & 7) != 0;
      m_ma = 1'($random(seed));
      m_vl = (k < 18) ? 0 : (k < 36) ? 32 : ($random(seed) & 63);
      m_vs = ($random(seed) & 3) ? 0 : ($random(seed) & 31);
      m_src2 = $random(seed);
      m_src1 = $random(seed);
      m_mask = $random(seed);
      m_dest = k[0] ? m_src2 : $random(seed);
      wrc(OFS_CTRL, {25'h000_0000, m_ma, m_sel, m_op}, RESP_OKAY);
      wrc(OFS_VLEN, 32'(m_vl), RESP_OKAY);
      if (m_vl > 32)
        m_vl = 32;
      wrc(OFS_VSTART, 32'(m_vs), RESP_OKAY);
      wrc(OFS_SRC2, m_src2, RESP_OKAY);
      wrc(OFS_SRC1, m_src1, RESP_OKAY);
      wrc(OFS_MASK, m_mask, RESP_OKAY);
      wrc(OFS_DEST, m_dest, RESP_OKAY); // destination equal to source two on odd passes
      wrc(OFS_GO, RST_WORD, RESP_OKAY);
      run_model();
      if (m_op <= OP_NOT)
        rdc(OFS_DEST, ALL, m_dest, RESP_OKAY);
      else
        rdc(OFS_DEST, ALL, m_dest, RESP_OKAY);
      rdc(OFS_SCALAR, ALL, m_scalar, RESP_OKAY);
      rdc(OFS_STATUS, st_m, e_st, RESP_OKAY);
      rdc(OFS_VSTART, ALL, RST_WORD, RESP_OKAY);
      wrc(OFS_STATUS, 32'h0000_0007, RESP_OKAY);
    end
    test_done();
  end
endmodule

/* File: test/vmo_axi_bfm.sv */
`timescale 1ns/10ps
// ------
// register bus master model
// ------
interface vmo_axi_bfm
  import vmo_pkg::*;
(
  // clock
  input wire logic clk
);
  // master requests and slave answers
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;

  // idle at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
  end

  // one write, address and data offered together, bounded wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    int n;
    ok = 1'b0;
    r = 2'h0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (n = 0; n < 64 && !ok; n++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask

  // one read, bounded wait
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    int n;
    ok = 1'b0;
    r = 2'h0;
    d = 32'h0000_0000;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 64 && !ok; n++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endinterface

/* File: test/vmo_top_props.sv */
`timescale 1ns/10ps
module vmo_top_props
  import vmo_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // write side
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  // read side
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP
);
  default clocking dck @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // channel transfers
  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  logic vs_zero_r, go_pend_r;

  // start index known clear once a go write has been answered
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      vs_zero_r <= 1'b1;
      go_pend_r <= 1'b0;
    end
    else if (aw_take)
    begin
      go_pend_r <= S_AXI_AWADDR == OFS_GO;
      if (S_AXI_AWADDR == OFS_VSTART)
        vs_zero_r <= 1'b0;
    end
    else if (S_AXI_BVALID && S_AXI_BREADY && go_pend_r)
      vs_zero_r <= 1'b1;
  end

  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
  ar_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  aw_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  read_answer_a: assert property (ar_take |=> S_AXI_RVALID)
    else $error("read answer late");
  write_answer_a: assert property (aw_take && w_take |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer timing wrong");
  unmapped_wr_a: assert property (aw_take && w_take && S_AXI_AWADDR > 8'h27
    |-> ##2 S_AXI_BRESP == RESP_SLVERR) else $error("unmapped write not refused");
  unmapped_rd_a: assert property (ar_take && S_AXI_ARADDR > 8'h27
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == RST_WORD) else $error("unmapped read");
  go_read_a: assert property (ar_take && S_AXI_ARADDR == OFS_GO
    |=> S_AXI_RDATA == RST_WORD && S_AXI_RRESP == RESP_OKAY) else $error("go reads nonzero");
  vstart_clear_a: assert property (
    ar_take && S_AXI_ARADDR == OFS_VSTART && vs_zero_r |=> S_AXI_RDATA == RST_WORD)
    else $error("start index not cleared");
endmodule

bind vmo_top vmo_top_props u_props (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP));
